// [ppol_regs.vh]
// Register map, field positions and reset values of the pin override block
`ifndef PPOL_REGS_VH
`define PPOL_REGS_VH

`define PPOL_NPINS          8
`define PPOL_ADDR_W         8

`define PPOL_OFS_DIR        8'h00
`define PPOL_OFS_LATCH      8'h04
`define PPOL_OFS_PIN        8'h08
`define PPOL_OFS_CTRL       8'h0C
`define PPOL_OFS_EDGE       8'h10

`define PPOL_CTRL_PUOFF     0

`define PPOL_RST_DIR        8'h00
`define PPOL_RST_LATCH      8'h00
`define PPOL_RST_CTRL       1'h0
`define PPOL_RST_EDGE       8'h00

`endif

// [ppol_pin_sync.v]
// Pin value synchroniser: low-phase stage followed by a rising-edge register
module ppol_pin_sync #(
  parameter WIDTH = 8
) (
  input  wire             clk_i,
  input  wire             rst_i,
  input  wire [WIDTH-1:0] d_i,
  output reg  [WIDTH-1:0] q_o
);

  reg [WIDTH-1:0] low_stage;

  // First stage holds through the low phase, so a pin edge reaches q_o
  // between half and one and a half clock periods later.
  always @(negedge clk_i) begin
    if (rst_i) begin
      low_stage <= {WIDTH{1'b0}};
    end else begin
      low_stage <= d_i;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      q_o <= {WIDTH{1'b0}};
    end else begin
      q_o <= low_stage;
    end
  end

endmodule

// [ppol_pin_cell.v]
// Override muxing for one pin: pull-up, driver enable, drive value, input enable
module ppol_pin_cell (
  input  wire dir_bit_i,
  input  wire latch_bit_i,
  input  wire global_pullup_off_i,
  input  wire sleep_i,
  input  wire ext_irq_en_i,
  input  wire pullup_override_en_i,
  input  wire pullup_override_val_i,
  input  wire dir_override_en_i,
  input  wire dir_override_val_i,
  input  wire outval_override_en_i,
  input  wire outval_override_val_i,
  input  wire input_en_override_en_i,
  input  wire input_en_override_val_i,
  output wire pullup_en_o,
  output wire drive_en_o,
  output wire drive_val_o,
  output wire input_en_o
);

  wire plain_pullup;
  wire plain_input_en;

  assign plain_pullup = ({dir_bit_i, latch_bit_i, global_pullup_off_i}
                         == 3'h2);
  assign pullup_en_o  = pullup_override_en_i ? pullup_override_val_i
                                             : plain_pullup;
  assign drive_en_o   = dir_override_en_i ? dir_override_val_i : dir_bit_i;
  assign drive_val_o  = outval_override_en_i ? outval_override_val_i
                                             : latch_bit_i;
  // sleep clamp, lifted for enabled external interrupt pins
  assign plain_input_en = ~sleep_i | ext_irq_en_i;
  assign input_en_o   = input_en_override_en_i ? input_en_override_val_i
                                               : plain_input_en;

endmodule

// [ppol_port.v]
// Port A pin override logic with APB register access
//
// The placing of the registers and the APB register port were left to the implementer.
`include "ppol_regs.vh"

module ppol_port (
  input  wire        clk_i,
  input  wire        rst_i,
  // APB slave
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [7:0]  paddr_i,
  input  wire [31:0] pwdata_i,
  output reg  [31:0] prdata_o,
  output reg         pready_o,
  output reg         pslverr_o,
  // Shared system controls
  input  wire        sleep_i,
  input  wire [7:0]  ext_irq_en_i,
  input  wire [7:0]  ext_edge_sense_i,
  // Per-pin overrides from peripherals
  input  wire [7:0]  pullup_override_en_i,
  input  wire [7:0]  pullup_override_val_i,
  input  wire [7:0]  dir_override_en_i,
  input  wire [7:0]  dir_override_val_i,
  input  wire [7:0]  outval_override_en_i,
  input  wire [7:0]  outval_override_val_i,
  input  wire [7:0]  latch_toggle_override_i,
  input  wire [7:0]  input_en_override_en_i,
  input  wire [7:0]  input_en_override_val_i,
  // Pad side
  input  wire [7:0]  pad_in_i,
  output wire [7:0]  pad_out_o,
  output wire [7:0]  pad_oe_o,
  output wire [7:0]  pad_pullup_o,
  // Analog line between pad and converter
  input  wire [7:0]  analog_pad_line_i,
  output wire [7:0]  analog_pad_line_o,
  input  wire [7:0]  analog_drive_i,
  input  wire [7:0]  analog_drive_en_i,
  output wire [7:0]  analog_pad_drive_o,
  output wire [7:0]  analog_pad_drive_oe_o,
  // Alternate-function taps
  output wire [7:0]  alt_func_input_tap_o,
  output wire [7:0]  pin_change_irq_src_o,
  output wire [7:0]  conv_channel_o,
  output reg  [7:0]  ext_edge_flag_o
);

  reg  [7:0] pin_direction_bit;
  reg  [7:0] output_latch_bit;
  reg        global_pullup_off;
  reg  [7:0] drive_en_q;
  reg  [7:0] drive_val_q;
  reg  [7:0] pullup_q;
  reg  [7:0] pin_prev;
  reg  [7:0] next_latch;
  reg  [7:0] next_edge;
  reg  [31:0] next_rdata;
  reg        next_err;

  wire [7:0] pullup_en;
  wire [7:0] drive_en;
  wire [7:0] drive_val;
  wire [7:0] input_en;
  wire [7:0] clamped_in;
  wire [7:0] pin_input_bit;
  wire       setup_ph;
  wire       wr_done;
  wire       addr_ok;
  wire       wr_dir;
  wire       wr_latch;
  wire       wr_pin;
  wire       wr_ctrl;
  wire       wr_edge;

  genvar n;
  generate
    for (n = 0; n < `PPOL_NPINS; n = n + 1) begin : g_pin
      ppol_pin_cell u_cell (
        .dir_bit_i               (pin_direction_bit[n]),
        .latch_bit_i             (output_latch_bit[n]),
        .global_pullup_off_i     (global_pullup_off),
        .sleep_i                 (sleep_i),
        .ext_irq_en_i            (ext_irq_en_i[n]),
        .pullup_override_en_i    (pullup_override_en_i[n]),
        .pullup_override_val_i   (pullup_override_val_i[n]),
        .dir_override_en_i       (dir_override_en_i[n]),
        .dir_override_val_i      (dir_override_val_i[n]),
        .outval_override_en_i    (outval_override_en_i[n]),
        .outval_override_val_i   (outval_override_val_i[n]),
        .input_en_override_en_i  (input_en_override_en_i[n]),
        .input_en_override_val_i (input_en_override_val_i[n]),
        .pullup_en_o             (pullup_en[n]),
        .drive_en_o              (drive_en[n]),
        .drive_val_o             (drive_val[n]),
        .input_en_o              (input_en[n])
      );
    end
  endgenerate

  assign clamped_in = pad_in_i & input_en;

  // tap before the synchroniser; users synchronise it themselves
  assign alt_func_input_tap_o = clamped_in;
  // pin n feeds pin-change source n and converter channel n
  assign pin_change_irq_src_o = clamped_in;
  assign conv_channel_o       = analog_pad_line_i;

  // analog path bypasses all digital logic
  assign analog_pad_line_o     = analog_pad_line_i;
  assign analog_pad_drive_o    = analog_drive_i;
  assign analog_pad_drive_oe_o = analog_drive_en_i;

  ppol_pin_sync #(
    .WIDTH (`PPOL_NPINS)
  ) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (clamped_in),
    .q_o   (pin_input_bit)
  );

  // Pad controls are registered; reset gates them without waiting for a
  // clock edge, which is the only combinational path to these outputs.
  // driver enable register
  always @(posedge clk_i) begin
    if (rst_i) begin
      drive_en_q <= 8'h00;
    end else begin
      drive_en_q <= drive_en;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      drive_val_q <= 8'h00;
    end else begin
      drive_val_q <= drive_val;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      pullup_q <= 8'h00;
    end else begin
      pullup_q <= pullup_en;
    end
  end

  // immediate tri-state in reset, per pin
  generate
    for (n = 0; n < `PPOL_NPINS; n = n + 1) begin : g_pad
      assign pad_oe_o[n]     = drive_en_q[n] & ~rst_i;
      assign pad_out_o[n]    = drive_val_q[n] & ~rst_i;
      // pull-ups held off through reset and while driving
      assign pad_pullup_o[n] = pullup_q[n] & ~rst_i & ~drive_en_q[n];
    end
  endgenerate

  // APB: one wait state, write takes effect on the pready edge
  assign setup_ph = psel_i & ~penable_i;
  assign wr_done  = psel_i & penable_i & pready_o & pwrite_i;
  assign addr_ok  = (paddr_i == `PPOL_OFS_DIR)   |
                    (paddr_i == `PPOL_OFS_LATCH) |
                    (paddr_i == `PPOL_OFS_PIN)   |
                    (paddr_i == `PPOL_OFS_CTRL)  |
                    (paddr_i == `PPOL_OFS_EDGE);

  // port-wide write strobes, one per register; the pins share them
  // while every override stays private to its own pin.
  assign wr_dir   = wr_done & (paddr_i == `PPOL_OFS_DIR);
  assign wr_latch = wr_done & (paddr_i == `PPOL_OFS_LATCH);
  assign wr_pin   = wr_done & (paddr_i == `PPOL_OFS_PIN);
  assign wr_ctrl  = wr_done & (paddr_i == `PPOL_OFS_CTRL);
  assign wr_edge  = wr_done & (paddr_i == `PPOL_OFS_EDGE);

  always @* begin
    next_rdata = 32'h0000_0000;
    next_err   = ~addr_ok;
    case (paddr_i)
      `PPOL_OFS_DIR:   next_rdata = {24'h000000, pin_direction_bit};
      `PPOL_OFS_LATCH: next_rdata = {24'h000000, output_latch_bit};
      `PPOL_OFS_PIN:   next_rdata = {24'h000000, pin_input_bit};
      `PPOL_OFS_CTRL:  next_rdata = {31'h00000000, global_pullup_off};
      `PPOL_OFS_EDGE:  next_rdata = {24'h000000, ext_edge_flag_o};
      default:         next_rdata = 32'h0000_0000;
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      pready_o  <= 1'b0;
      prdata_o  <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end else begin
      // One wait state: the answer stands in the second access cycle only
      if (psel_i && penable_i && !pready_o) begin
        pready_o <= 1'b1;
      end else begin
        pready_o <= 1'b0;
      end
      // Read data sampled in setup; the register view is two cycles old when pready is sampled
      if (setup_ph) begin
        pslverr_o <= next_err;
        if (pwrite_i) begin
          prdata_o <= 32'h0000_0000;
        end else begin
          prdata_o <= next_rdata;
        end
      end
    end
  end

  // Latch: register write, then pin-register toggle, then peripheral toggle
  always @* begin
    next_latch = output_latch_bit;
    if (wr_latch) begin
      next_latch = pwdata_i[7:0];
    end
    if (wr_pin) begin
      next_latch = next_latch ^ pwdata_i[7:0];
    end
    next_latch = next_latch ^ latch_toggle_override_i;
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      pin_direction_bit <= `PPOL_RST_DIR;
      output_latch_bit  <= `PPOL_RST_LATCH;
      global_pullup_off <= `PPOL_RST_CTRL;
    end else begin
      output_latch_bit <= next_latch;
      if (wr_dir) begin
        pin_direction_bit <= pwdata_i[7:0];
      end
      if (wr_ctrl) begin
        global_pullup_off <= pwdata_i[`PPOL_CTRL_PUOFF];
      end
    end
  end

  // rising edge seen after the clamp lifts; set wins over clear
  always @* begin
    next_edge = ext_edge_flag_o;
    if (wr_edge) begin
      next_edge = next_edge & ~pwdata_i[7:0];
    end
    next_edge = next_edge | (pin_input_bit & ~pin_prev & ext_edge_sense_i);
  end

  // Previous synchronised level restarts low, so a pin held high across
  // reset reports one rising edge if its sensing is configured.
  always @(posedge clk_i) begin
    if (rst_i) begin
      pin_prev <= 8'h00;
    end else begin
      pin_prev <= pin_input_bit;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      ext_edge_flag_o <= `PPOL_RST_EDGE;
    end else begin
      ext_edge_flag_o <= next_edge;
    end
  end

endmodule

// [ppol_port_sva.sv]
// Port-level assertions for the pin override block
module ppol_port_sva (
  input logic       clk_i,
  input logic       rst_i,
  input logic       psel_i,
  input logic       penable_i,
  input logic       pready_o,
  input logic       sleep_i,
  input logic [7:0] ext_irq_en_i,
  input logic [7:0] pullup_override_en_i,
  input logic [7:0] pullup_override_val_i,
  input logic [7:0] dir_override_en_i,
  input logic [7:0] dir_override_val_i,
  input logic [7:0] outval_override_en_i,
  input logic [7:0] outval_override_val_i,
  input logic [7:0] input_en_override_en_i,
  input logic [7:0] input_en_override_val_i,
  input logic [7:0] pad_in_i,
  input logic [7:0] pad_out_o,
  input logic [7:0] pad_oe_o,
  input logic [7:0] pad_pullup_o,
  input logic [7:0] analog_pad_line_i,
  input logic [7:0] analog_pad_line_o,
  input logic [7:0] alt_func_input_tap_o,
  input logic [7:0] pin_change_irq_src_o,
  input logic [7:0] conv_channel_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_setup;
    psel_i && !penable_i;
  endsequence
  sequence s_answer;
    !pready_o ##1 pready_o ##1 !pready_o;
  endsequence
  AST_APB_READY: // Fixed answer
    assert property (s_setup |=> s_answer) else $error("pready late");
  AST_RST_SAFE:
    assert property (disable iff (1'b0) rst_i |->
      (pad_oe_o | pad_pullup_o) == 8'h00) else $error("pad live");
  AST_DIR_OVR:
    assert property (!rst_i |=> ((pad_oe_o ^ $past(dir_override_val_i))
      & $past(dir_override_en_i)) == 8'h00) else $error("oe wrong");
  AST_OUT_OVR:
    assert property (!rst_i |=> ((pad_out_o ^ $past(outval_override_val_i))
      & $past(outval_override_en_i) & pad_oe_o) == 8'h00)
      else $error("out wrong");
  AST_PU_OVR:
    assert property (!rst_i |=> ((pad_pullup_o ^ $past(pullup_override_val_i))
      & $past(pullup_override_en_i) & ~pad_oe_o) == 8'h00)
      else $error("pullup wrong");
  AST_IE_OVR:
    assert property (((alt_func_input_tap_o ^ (pad_in_i
      & input_en_override_val_i)) & input_en_override_en_i) == 8'h00)
      else $error("tap wrong");
  AST_SLEEP_CLAMP:
    assert property (((alt_func_input_tap_o ^ (pad_in_i & ~({8{sleep_i}}
      & ~ext_irq_en_i))) & ~input_en_override_en_i) == 8'h00)
      else $error("clamp wrong");
  AST_ROUTE:
    assert property (pin_change_irq_src_o == alt_func_input_tap_o
      && conv_channel_o == analog_pad_line_i
      && analog_pad_line_o == analog_pad_line_i) else $error("route");
endmodule

// [ppol_periph_model.sv]
// Peripheral-side model that drives the per-pin override signals
module ppol_periph_model (
  input  logic        clk_i,
  output logic [71:0] ovr_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial ovr_o = 72'h0;
  task automatic drive(input logic [71:0] v);
    @(posedge clk_i);
    ovr_o <= v;
  endtask
endmodule

// [ppol_port_bench.sv]
// Self-checking bench for the pin override block
`include "ppol_regs.vh"
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin \
  mismatches++; $display("BAD %0t got %h want %h", $time, a, b); end end
module ppol_port_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i, rst_i, psel_i, penable_i, pwrite_i, sleep_i, pready_o;
  logic pslverr_o, err;
  logic [7:0] paddr_i, ext_irq_en_i, ext_edge_sense_i, pad_in_i;
  logic [7:0] analog_pad_line_i, analog_drive_i, analog_drive_en_i;
  logic [31:0] pwdata_i, prdata_o, rd;
  logic [7:0] pad_out_o, pad_oe_o, pad_pullup_o, analog_pad_line_o;
  logic [7:0] analog_pad_drive_o, analog_pad_drive_oe_o, conv_channel_o;
  logic [7:0] alt_func_input_tap_o, pin_change_irq_src_o, ext_edge_flag_o;
  logic [7:0] pullup_override_en_i, pullup_override_val_i;
  logic [7:0] dir_override_en_i, dir_override_val_i;
  logic [7:0] outval_override_en_i, outval_override_val_i;
  logic [7:0] latch_toggle_override_i, input_en_override_en_i;
  logic [7:0] input_en_override_val_i;
  logic [71:0] ovr, v;
  int mismatches, cmp_count, seed, dir, lat, puoff;
  ppol_port dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .sleep_i(sleep_i), .ext_irq_en_i(ext_irq_en_i),
    .ext_edge_sense_i(ext_edge_sense_i),
    .pullup_override_en_i(pullup_override_en_i),
    .pullup_override_val_i(pullup_override_val_i),
    .dir_override_en_i(dir_override_en_i),
    .dir_override_val_i(dir_override_val_i),
    .outval_override_en_i(outval_override_en_i),
    .outval_override_val_i(outval_override_val_i),
    .latch_toggle_override_i(latch_toggle_override_i),
    .input_en_override_en_i(input_en_override_en_i),
    .input_en_override_val_i(input_en_override_val_i),
    .pad_in_i(pad_in_i), .pad_out_o(pad_out_o), .pad_oe_o(pad_oe_o),
    .pad_pullup_o(pad_pullup_o), .analog_pad_line_i(analog_pad_line_i),
    .analog_pad_line_o(analog_pad_line_o),
    .analog_drive_i(analog_drive_i), .analog_drive_en_i(analog_drive_en_i),
    .analog_pad_drive_o(analog_pad_drive_o),
    .analog_pad_drive_oe_o(analog_pad_drive_oe_o),
    .alt_func_input_tap_o(alt_func_input_tap_o),
    .pin_change_irq_src_o(pin_change_irq_src_o),
    .conv_channel_o(conv_channel_o), .ext_edge_flag_o(ext_edge_flag_o)
  );
  ppol_periph_model per_u (.clk_i(clk_i), .ovr_o(ovr));
  assign {pullup_override_en_i, pullup_override_val_i, dir_override_en_i,
    dir_override_val_i, outval_override_en_i, outval_override_val_i,
    latch_toggle_override_i, input_en_override_en_i,
    input_en_override_val_i} = ovr;
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task automatic finish_test;
    $display("Compared %0d mismatched %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    if (pready_o !== 1'b1) begin
      mismatches++;
      finish_test();
    end
    // Answer taken on the edge that samples pready
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic check_pins;
    logic [7:0] pe, pv, de, dv, ve, vv, tg, ien, iev, o, t;
    {pe, pv, de, dv, ve, vv, tg, ien, iev} = v;
    o = (de & dv) | (~de & dir[7:0]);
    `CHK(pad_oe_o, o)
    `CHK(pad_out_o & o, ((ve & vv) | (~ve & lat[7:0])) & o)
    `CHK(pad_pullup_o & ~o, ((pe & pv) | (~pe & ~dir[7:0] & lat[7:0]
      & {8{puoff == 0}})) & ~o)
    t = pad_in_i & ((ien & iev)
      | (~ien & ~({8{sleep_i}} & ~ext_irq_en_i)));
    `CHK(alt_func_input_tap_o, t)
    `CHK(pin_change_irq_src_o, t)
    `CHK(conv_channel_o, analog_pad_line_i)
    `CHK(analog_pad_line_o, analog_pad_line_i)
    `CHK(analog_pad_drive_o, analog_drive_i)
    `CHK(analog_pad_drive_oe_o, analog_drive_en_i)
  endtask
  initial begin
    seed = 30;
    rst_i = 1'b1;
    psel_i = 1'b0;
    penable_i = 1'b0;
    pwrite_i = 1'b0;
    paddr_i = 8'h00;
    pwdata_i = 32'h0;
    sleep_i = 1'b0;
    ext_irq_en_i = 8'h00;
    ext_edge_sense_i = 8'h00;
    pad_in_i = 8'h00;
    analog_pad_line_i = 8'h00;
    analog_drive_i = 8'h00;
    analog_drive_en_i = 8'h00;
    v = 72'h0;
    repeat (4) @(posedge clk_i);
    `CHK(pad_oe_o | pad_pullup_o, 8'h00)
    rst_i <= 1'b0;
    apb(1'b0, `PPOL_OFS_DIR, 32'h0);
    `CHK(rd, 32'h0)
    apb(1'b1, `PPOL_OFS_LATCH, 32'h3C);
    apb(1'b1, `PPOL_OFS_PIN, 32'hFF);
    apb(1'b0, `PPOL_OFS_LATCH, 32'h0);
    `CHK(rd, 32'hC3)
    // A one-cycle toggle pulse flips bit 0 exactly once
    per_u.drive(72'h01 << 16);
    per_u.drive(72'h0);
    apb(1'b0, `PPOL_OFS_LATCH, 32'h0);
    `CHK(rd, 32'hC2)
    apb(1'b0, 8'h40, 32'h0);
    `CHK(err, 1'b1)
    pad_in_i <= 8'hA5;
    repeat (3) @(posedge clk_i);
    apb(1'b0, `PPOL_OFS_PIN, 32'h0);
    `CHK(rd, 32'hA5)
    ext_edge_sense_i <= 8'h01;
    sleep_i <= 1'b1;
    apb(1'b1, `PPOL_OFS_EDGE, 32'hFF);
    sleep_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    `CHK(ext_edge_flag_o[0], 1'b1)
    apb(1'b1, `PPOL_OFS_EDGE, 32'hFF);
    apb(1'b0, `PPOL_OFS_EDGE, 32'h0);
    `CHK(rd, 32'h0)
    `CHK(err, 1'b0)
    for (int i = 0; i < 24; i++) begin
      dir = $random(seed);
      lat = $random(seed);
      puoff = $random(seed) & 1;
      apb(1'b1, `PPOL_OFS_DIR, dir);
      apb(1'b1, `PPOL_OFS_LATCH, lat);
      apb(1'b1, `PPOL_OFS_CTRL, puoff);
      sleep_i <= 1'($random(seed));
      ext_irq_en_i <= 8'($random(seed));
      pad_in_i <= 8'($random(seed));
      analog_pad_line_i <= 8'($random(seed));
      analog_drive_i <= 8'($random(seed));
      analog_drive_en_i <= 8'($random(seed));
      v[31:0] = $random(seed);
      v[63:32] = $random(seed);
      v[71:64] = 8'($random(seed));
      v[23:16] = 8'h00;
      per_u.drive(v);
      repeat (2) @(posedge clk_i);
      #1 check_pins();
    end
    // Second reset while the port drives: pads must release at once
    apb(1'b1, `PPOL_OFS_DIR, 32'hFF);
    rst_i <= 1'b1;
    #1;
    `CHK(pad_oe_o | pad_out_o | pad_pullup_o, 8'h00)
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    apb(1'b0, `PPOL_OFS_DIR, 32'h0);
    `CHK(rd, 32'h0)
    apb(1'b0, `PPOL_OFS_LATCH, 32'h0);
    `CHK(rd, 32'h0)
    finish_test();
  end
endmodule
bind ppol_port ppol_port_sva chk_u (
  .clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
  .pready_o(pready_o), .sleep_i(sleep_i), .ext_irq_en_i(ext_irq_en_i),
  .pullup_override_en_i(pullup_override_en_i),
  .pullup_override_val_i(pullup_override_val_i),
  .dir_override_en_i(dir_override_en_i),
  .dir_override_val_i(dir_override_val_i),
  .outval_override_en_i(outval_override_en_i),
  .outval_override_val_i(outval_override_val_i),
  .input_en_override_en_i(input_en_override_en_i),
  .input_en_override_val_i(input_en_override_val_i),
  .pad_in_i(pad_in_i), .pad_out_o(pad_out_o), .pad_oe_o(pad_oe_o),
  .pad_pullup_o(pad_pullup_o), .analog_pad_line_i(analog_pad_line_i),
  .analog_pad_line_o(analog_pad_line_o),
  .alt_func_input_tap_o(alt_func_input_tap_o),
  .pin_change_irq_src_o(pin_change_irq_src_o),
  .conv_channel_o(conv_channel_o)
);
